//--- core/mre_pkg.sv
package mre_pkg;

   // Clock and response time limit
   localparam int CLK_HZ      = 125_000_000;
   localparam int TIMEOUT_MS  = 500;
   localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int TIMER_W     = 26;

   // Status word layout
   localparam int STAT_DONE_BIT = 0;
   localparam int STAT_ERR_BIT  = 1;
   localparam int STAT_CODE_LSB = 8;
   localparam logic [15:0] STAT_RESET = 16'h0000;

   // Error codes carried in the status word
   localparam logic [7:0] ERR_NONE    = 8'h00;
   localparam logic [7:0] ERR_FUNC    = 8'h01;
   localparam logic [7:0] ERR_ADDR    = 8'h02;
   localparam logic [7:0] ERR_DATA    = 8'h03;
   localparam logic [7:0] ERR_FAIL    = 8'h04;
   localparam logic [7:0] ERR_ACK     = 8'h05;
   localparam logic [7:0] ERR_BUSY    = 8'h06;
   localparam logic [7:0] ERR_TIMEOUT = 8'h07;
   localparam logic [7:0] ERR_COUNT   = 8'h08;
   localparam logic [7:0] ERR_PARAM   = 8'h09;
   localparam logic [7:0] ERR_STATION = 8'h0A;

   // Function codes
   localparam logic [7:0] FC_RD_COILS  = 8'h01;
   localparam logic [7:0] FC_RD_INPUTS = 8'h02;
   localparam logic [7:0] FC_RD_HOLD   = 8'h03;
   localparam logic [7:0] FC_RD_INREG  = 8'h04;
   localparam logic [7:0] FC_WR_COIL   = 8'h05;
   localparam logic [7:0] FC_WR_REG    = 8'h06;
   localparam logic [7:0] FC_WR_COILS  = 8'h0F;
   localparam logic [7:0] FC_WR_REGS   = 8'h10;
   localparam logic [7:0] EXC_FLAG     = 8'h80;

   // Frame and range figures
   localparam logic [7:0]  BCAST_STATION = 8'h00;
   localparam logic [3:0]  REQ_LAST_IDX  = 4'h5;
   localparam logic [2:0]  SREQ_LAST_IDX = 3'h5;
   localparam logic [16:0] MAX_BYTES     = 17'h00100;
   localparam int          SLAVE_BITS    = 64;
   localparam logic [16:0] SLAVE_LIMIT   = 17'h00040;
   localparam logic [1:0]  LEGACY_CHAN   = 2'h0;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SEND  = 3'b001,
      ST_WAIT  = 3'b011,
      ST_HOLD  = 3'b010,
      ST_SRESP = 3'b110
   } mre_state_type;

   function automatic logic mre_fc_valid(input logic [7:0] fc);
      case (fc)
         FC_RD_COILS, FC_RD_INPUTS, FC_RD_HOLD, FC_RD_INREG,
         FC_WR_COIL, FC_WR_REG, FC_WR_COILS, FC_WR_REGS: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // Data bytes implied by a function code and item count
   function automatic logic [16:0] mre_byte_count(input logic [7:0] fc,
                                                  input logic [15:0] n);
      case (fc)
         FC_RD_COILS, FC_RD_INPUTS, FC_WR_COILS:
            return ({1'b0, n} + 17'h00007) >> 3;
         FC_RD_HOLD, FC_RD_INREG, FC_WR_REGS: return {n, 1'b0};
         default: return 17'h00001;
      endcase
   endfunction

endpackage

//--- core/mre_timer.sv
module mre_timer import mre_pkg::*; #(
   parameter int CYCLES = TIMEOUT_CYC
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // Control
   input  wire logic start,
   input  wire logic stop,
   // Expiry pulse
   output logic      expired
);

   logic [TIMER_W-1:0] count;
   logic               running;

   always_ff @(posedge clock) begin
      if (rst) begin
         running <= 1'b0;
         count   <= '0;
         expired <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (start) begin
            running <= 1'b1;
            count   <= TIMER_W'(CYCLES - 1);
         end else if (stop) begin
            running <= 1'b0;
         end else if (running) begin
            if (count == '0) begin
               running <= 1'b0;
               expired <= 1'b1;
            end else begin
               count <= count - TIMER_W'(1);
            end
         end
      end
   end

endmodule

//--- core/mre_bit_pack.sv
module mre_bit_pack import mre_pkg::*; (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // Byte stream
   input  wire logic       clear,
   input  wire logic       byte_valid,
   input  wire logic [7:0] byte_data,
   input  wire logic       flush,
   // Word buffer write port
   output logic            buf_we,
   output logic [7:0]      buf_addr,
   output logic [15:0]     buf_data
);

   logic [7:0] low;
   logic       half;
   logic [7:0] addr_n;

   // Earlier byte in the low half; odd tail padded with zero
   always_ff @(posedge clock) begin
      if (rst) begin
         low      <= 8'h00;
         half     <= 1'b0;
         addr_n   <= 8'h00;
         buf_we   <= 1'b0;
         buf_addr <= 8'h00;
         buf_data <= 16'h0000;
      end else begin
         buf_we <= 1'b0;
         if (byte_valid) begin
            if (!half) begin
               low  <= byte_data;
               half <= 1'b1;
            end else begin
               buf_data <= {byte_data, low};
               buf_addr <= addr_n;
               buf_we   <= 1'b1;
               addr_n   <= addr_n + 8'h01;
               half     <= 1'b0;
            end
         end else if (flush) begin
            if (half) begin
               buf_data <= {8'h00, low};
               buf_addr <= addr_n;
               buf_we   <= 1'b1;
               half     <= 1'b0;
            end
         end else if (clear) begin
            half   <= 1'b0;
            addr_n <= 8'h00;
         end
      end
   end

endmodule

//--- core/mre_engine.sv
// Summary of operation
// R1: Master sends request frame on execution rise
// R2: Slave answers valid requests on its own
// R3: Done flag high exactly one cycle
// R4: Error flag one cycle, code in bits 15:8
// R5: Code 01 for invalid function code
// R6: Code 02 for range beyond slave area
// R7: Code 03 for disallowed data value
// R8: Code 04 when slave reports internal failure
// R9: Code 05 recorded, wait without reissue
// R10: Busy code 06: issuing logic retries
// R11: Code 07 when no response in time
// R12: Code 08 for zero or over 256 bytes
// R13: Code 09 for inconsistent parameter settings
// R14: Code 10 when target equals own station
// R15: Legacy instruction always uses channel 0
// R16: Descriptor holds user address minus one
// R17: Bit reads packed LSB first, zero pad
// R18: Function 01 reads coil status bits
// R19: Done at bit 0, error bit 1
// R20: Response timeout configurable, default 500 ms
// R21: Station number 0 to 31, 0 broadcast
module mre_engine import mre_pkg::*; #(
   parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
   // Clock and reset
   input  wire logic                  clock,
   input  wire logic                  rst,
   // Configuration
   input  wire logic                  cfg_master,
   input  wire logic                  cfg_ascii_mode,
   input  wire logic                  cfg_data_bits8,
   input  wire logic [4:0]            own_station,
   input  wire logic                  legacy_instruction,
   input  wire logic [1:0]            channel_select,
   // Request descriptor
   input  wire logic                  exec_condition,
   input  wire logic [7:0]            req_station,
   input  wire logic [7:0]            req_function,
   input  wire logic [15:0]           req_address,
   input  wire logic [15:0]           req_count,
   // Status
   output logic [15:0]                transaction_status_word,
   output logic [1:0]                 active_channel,
   // Transmit byte stream
   output logic                       tx_valid,
   output logic [7:0]                 tx_data,
   output logic                       tx_last,
   input  wire logic                  tx_ready,
   // Receive byte stream
   input  wire logic                  rx_valid,
   input  wire logic [7:0]            rx_data,
   input  wire logic                  rx_last,
   // Receive buffer write port
   output logic                       buf_we,
   output logic [7:0]                 buf_addr,
   output logic [15:0]                buf_data,
   // Slave bit image
   input  wire logic [SLAVE_BITS-1:0] slave_bits
);

   mre_state_type state;
   logic          exec_d;
   logic          exec_rise;
   logic [7:0]    d_station;
   logic [7:0]    d_func;
   logic [15:0]   d_addr;
   logic [15:0]   d_count;
   logic [3:0]    idx;
   logic [8:0]    ridx;
   logic          resp_exc;
   logic [7:0]    resp_code;
   logic [7:0]    exc_now;
   logic [2:0]    sidx;
   logic [7:0]    s_station;
   logic [7:0]    s_func;
   logic [15:0]   s_addr;
   logic [15:0]   s_count;
   logic          s_pend;
   logic          s_exc;
   logic [7:0]    s_code;
   logic [3:0]    s_len;
   logic          flush_q;
   logic          cfg_bad;
   logic          stn_bad;
   logic          cnt_bad;
   logic [7:0]    check_code;
   logic [7:0]    next_s_code;
   logic [7:0]    next_tx_byte;
   logic [3:0]    s_nbytes;
   logic          tmr_start;
   logic          tmr_stop;
   logic          tmr_exp;
   logic          pk_valid;
   logic          resp_end;

   function automatic logic [7:0] slave_data(input logic [SLAVE_BITS-1:0] bits,
                                             input logic [15:0] first,
                                             input logic [15:0] n,
                                             input logic [3:0] k);
      logic [7:0] b;
      int         pos;
      b = 8'h00;
      for (int i = 0; i < 8; i++) begin
         pos = 8 * int'(k) + i;
         if (pos < int'(n) && (pos + int'(first)) < SLAVE_BITS)
            b[i] = bits[pos + int'(first)];
      end
      return b;
   endfunction

   assign exec_rise = exec_condition && !exec_d;
   assign resp_end  = state == ST_WAIT && rx_valid && rx_last;
   // Code byte can be the last one: use it as it arrives
   assign exc_now   = ridx == 9'h002 ? rx_data : resp_code;

   // R13: parameter check
   assign cfg_bad = (cfg_ascii_mode == cfg_data_bits8) || !cfg_master;
   // R14: station check
   assign stn_bad = req_station == {3'h0, own_station};
   // R12: count check
   assign cnt_bad = req_function != FC_WR_COIL && req_function != FC_WR_REG
                    && (req_count == 16'h0000
                    || mre_byte_count(req_function, req_count) > MAX_BYTES);

   always_comb begin
      if (cfg_bad)
         check_code = ERR_PARAM;
      else if (stn_bad)
         check_code = ERR_STATION;
      // R5: invalid function
      else if (!mre_fc_valid(req_function))
         check_code = ERR_FUNC;
      else if (cnt_bad)
         check_code = ERR_COUNT;
      else
         check_code = ERR_NONE;
   end

   // R17: LSB first, unused bits zero
   assign s_nbytes = 4'(({1'b0, s_count} + 17'h00007) >> 3);

   always_comb begin
      next_s_code = ERR_NONE;
      if (s_func != FC_RD_COILS && s_func != FC_RD_INPUTS)
         next_s_code = ERR_FUNC;
      else if (s_count == 16'h0000 || {1'b0, s_count} > SLAVE_LIMIT)
         next_s_code = ERR_DATA;
      else if ({1'b0, s_addr} + {1'b0, s_count} > SLAVE_LIMIT)
         next_s_code = ERR_ADDR;
   end

   always_comb begin
      next_tx_byte = 8'h00;
      if (state == ST_SEND) begin
         case (idx)
            4'h0: next_tx_byte = d_func;
            4'h1: next_tx_byte = d_addr[15:8];
            4'h2: next_tx_byte = d_addr[7:0];
            4'h3: next_tx_byte = d_count[15:8];
            default: next_tx_byte = d_count[7:0];
         endcase
      end else begin
         case (idx)
            4'h0: next_tx_byte = s_exc ? (s_func | EXC_FLAG) : s_func;
            4'h1: next_tx_byte = s_exc ? s_code : {4'h0, s_nbytes};
            default: next_tx_byte = slave_data(slave_bits, s_addr, s_count,
                                               4'(idx - 4'h2));
         endcase
      end
   end

   // R20: response timer, also spaces the acknowledge wait
   assign tmr_start = (state == ST_SEND && tx_ready && idx == REQ_LAST_IDX
                       && d_station != BCAST_STATION)
                      || (resp_end && resp_exc && exc_now == ERR_ACK);
   assign tmr_stop  = resp_end;
   assign pk_valid  = state == ST_WAIT && rx_valid && ridx >= 9'h003
                      && !resp_exc;

   always_ff @(posedge clock) begin
      if (rst)
         exec_d <= 1'b0;
      else
         exec_d <= exec_condition;
   end

   // R15: legacy form pinned to channel 0
   always_ff @(posedge clock) begin
      if (rst)
         active_channel <= LEGACY_CHAN;
      else
         active_channel <= legacy_instruction ? LEGACY_CHAN : channel_select;
   end

   always_ff @(posedge clock) begin
      if (rst)
         flush_q <= 1'b0;
      else
         flush_q <= resp_end;
   end

   // Slave request capture runs only while idle as slave
   always_ff @(posedge clock) begin
      if (rst) begin
         sidx      <= 3'h0;
         s_station <= 8'h00;
         s_func    <= 8'h00;
         s_addr    <= 16'h0000;
         s_count   <= 16'h0000;
         s_pend    <= 1'b0;
      end else begin
         s_pend <= 1'b0;
         if (state == ST_IDLE && !cfg_master && rx_valid) begin
            sidx <= rx_last ? 3'h0 : sidx + 3'h1;
            case (sidx)
               3'h0: s_station <= rx_data;
               3'h1: s_func <= rx_data;
               3'h2: s_addr[15:8] <= rx_data;
               3'h3: s_addr[7:0] <= rx_data;
               3'h4: s_count[15:8] <= rx_data;
               default: s_count[7:0] <= rx_data;
            endcase
            // R21: broadcast is never answered
            if (rx_last && sidx == SREQ_LAST_IDX
                && s_station == {3'h0, own_station}
                && s_station != BCAST_STATION)
               s_pend <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state     <= ST_IDLE;
         transaction_status_word <= STAT_RESET;
         tx_valid  <= 1'b0;
         tx_data   <= 8'h00;
         tx_last   <= 1'b0;
         idx       <= 4'h0;
         ridx      <= 9'h000;
         resp_exc  <= 1'b0;
         resp_code <= ERR_NONE;
         d_station <= 8'h00;
         d_func    <= 8'h00;
         d_addr    <= 16'h0000;
         d_count   <= 16'h0000;
         s_exc     <= 1'b0;
         s_code    <= ERR_NONE;
         s_len     <= 4'h0;
      end else begin
         // R19: done bit 0, error bit 1
         // R3: done lasts one cycle
         transaction_status_word[STAT_DONE_BIT] <= 1'b0;
         // R4: error lasts one cycle
         transaction_status_word[STAT_ERR_BIT] <= 1'b0;
         case (state)
            ST_IDLE: begin
               ridx     <= 9'h000;
               resp_exc <= 1'b0;
               if (s_pend) begin
                  // R2: automatic slave answer
                  s_exc    <= next_s_code != ERR_NONE;
                  s_code   <= next_s_code;
                  s_len    <= next_s_code != ERR_NONE ? 4'h2
                              : 4'(s_nbytes + 4'h2);
                  idx      <= 4'h0;
                  tx_valid <= 1'b1;
                  tx_data  <= {3'h0, own_station};
                  tx_last  <= 1'b0;
                  state    <= ST_SRESP;
               end else if (exec_rise && (cfg_master || cfg_bad)) begin
                  if (check_code != ERR_NONE) begin
                     // R4: code into the upper byte
                     transaction_status_word[STAT_ERR_BIT] <= 1'b1;
                     transaction_status_word[15:STAT_CODE_LSB] <= check_code;
                  end else begin
                     // R1: start of request frame
                     d_station <= req_station;
                     d_func    <= req_function;
                     d_addr    <= req_address;
                     d_count   <= req_count;
                     idx       <= 4'h0;
                     tx_valid  <= 1'b1;
                     tx_data   <= req_station;
                     tx_last   <= 1'b0;
                     state     <= ST_SEND;
                  end
               end
            end
            ST_SEND, ST_SRESP: begin
               if (tx_ready) begin
                  if (tx_last) begin
                     tx_valid <= 1'b0;
                     tx_last  <= 1'b0;
                     if (state == ST_SRESP)
                        state <= ST_IDLE;
                     else if (d_station == BCAST_STATION) begin
                        transaction_status_word[STAT_DONE_BIT] <= 1'b1;
                        state <= ST_IDLE;
                     end else
                        state <= ST_WAIT;
                  end else begin
                     idx     <= idx + 4'h1;
                     tx_data <= next_tx_byte;
                     tx_last <= state == ST_SEND ? idx == REQ_LAST_IDX - 4'h1
                                                 : idx + 4'h1 == s_len;
                  end
               end
            end
            ST_WAIT: begin
               if (rx_valid) begin
                  ridx <= ridx + 9'h001;
                  if (ridx == 9'h001)
                     resp_exc <= rx_data[7];
                  if (ridx == 9'h002 && resp_exc)
                     resp_code <= rx_data;
               end
               if (resp_end) begin
                  if (resp_exc) begin
                     // R6: R7: R8: slave code reported as given
                     transaction_status_word[STAT_ERR_BIT] <= 1'b1;
                     transaction_status_word[15:STAT_CODE_LSB] <= exc_now;
                     // R9: acknowledge waits, no reissue
                     state <= exc_now == ERR_ACK ? ST_HOLD : ST_IDLE;
                  end else begin
                     transaction_status_word[STAT_DONE_BIT] <= 1'b1;
                     state <= ST_IDLE;
                  end
               end else if (tmr_exp) begin
                  // R11: no answer in time
                  transaction_status_word[STAT_ERR_BIT] <= 1'b1;
                  transaction_status_word[15:STAT_CODE_LSB] <= ERR_TIMEOUT;
                  state <= ST_IDLE;
               end
            end
            ST_HOLD: begin
               if (tmr_exp)
                  state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   mre_timer #(.CYCLES(TIMEOUT_CYCLES)) u_timer (
      .clock   (clock),
      .rst     (rst),
      .start   (tmr_start),
      .stop    (tmr_stop),
      .expired (tmr_exp)
   );

   // R18: coil bytes packed two to a word
   mre_bit_pack u_pack (
      .clock      (clock),
      .rst        (rst),
      .clear      (state == ST_IDLE),
      .byte_valid (pk_valid),
      .byte_data  (rx_data),
      .flush      (flush_q),
      .buf_we     (buf_we),
      .buf_addr   (buf_addr),
      .buf_data   (buf_data)
   );

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_exec_ok;
      state == ST_IDLE && !s_pend && exec_rise && check_code == ERR_NONE;
   endsequence

   property p_done_pulse;
      transaction_status_word[STAT_DONE_BIT]
         |=> !transaction_status_word[STAT_DONE_BIT];
   endproperty
   a_done_pulse: assert property (p_done_pulse) // R3
      else $error("done flag held beyond one cycle");

   property p_err_pulse;
      transaction_status_word[STAT_ERR_BIT]
         |-> transaction_status_word[15:8] != ERR_NONE
             ##1 !transaction_status_word[STAT_ERR_BIT];
   endproperty
   a_err_pulse: assert property (p_err_pulse) // R4
      else $error("error flag not a coded one-cycle pulse");

   property p_start;
      s_exec_ok |=> tx_valid && tx_data == $past(req_station)
                    && state == ST_SEND;
   endproperty
   a_start: assert property (p_start) // R1
      else $error("request frame did not start");

   property p_param;
      state == ST_IDLE && !s_pend && exec_rise && cfg_bad
         |=> transaction_status_word[STAT_ERR_BIT]
             && transaction_status_word[15:8] == ERR_PARAM;
   endproperty
   a_param: assert property (p_param) // R13
      else $error("parameter error not reported");

   property p_station;
      state == ST_IDLE && !s_pend && exec_rise && !cfg_bad && stn_bad
         |=> transaction_status_word[15:8] == ERR_STATION;
   endproperty
   a_station: assert property (p_station) // R14
      else $error("station error not reported");

   property p_func;
      state == ST_IDLE && !s_pend && exec_rise && !cfg_bad && !stn_bad
         && !mre_fc_valid(req_function)
         |=> transaction_status_word[15:8] == ERR_FUNC;
   endproperty
   a_func: assert property (p_func) // R5
      else $error("function error not reported");

   property p_count;
      state == ST_IDLE && !s_pend && exec_rise && !cfg_bad && !stn_bad
         && req_function == FC_RD_COILS && req_count == 16'h0000
         |=> transaction_status_word[15:8] == ERR_COUNT;
   endproperty
   a_count: assert property (p_count) // R12
      else $error("count error not reported");

   property p_timeout;
      state == ST_WAIT && tmr_exp && !resp_end
         |=> state == ST_IDLE && transaction_status_word[15:8] == ERR_TIMEOUT;
   endproperty
   a_timeout: assert property (p_timeout) // R11
      else $error("timeout not reported");

   property p_channel;
      legacy_instruction |=> active_channel == LEGACY_CHAN;
   endproperty
   a_channel: assert property (p_channel) // R15
      else $error("legacy form left channel 0");

   property p_hold;
      state == ST_HOLD |-> !tx_valid && transaction_status_word[15:8] == ERR_ACK;
   endproperty
   a_hold: assert property (p_hold) // R9
      else $error("acknowledge wait broken");

   property p_slave;
      s_pend && state == ST_IDLE
         |=> state == ST_SRESP && tx_valid && tx_data == {3'h0, own_station};
   endproperty
   a_slave: assert property (p_slave) // R2
      else $error("slave did not answer");

endmodule

//--- test/mre_remote_station.sv
module mre_remote_station import mre_pkg::*; (
   // Clock
   input  wire logic       clock,
   // Request bytes
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_last,
   output logic            tx_ready,
   // Answer bytes
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   output logic            rx_last,
   // Answer kind: 0 data, 1 exception, 2 silent, 3 ask as master
   input  wire logic [1:0] mode,
   input  wire logic [7:0] exc_code
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] req [11];
   logic       asked = 1'b0;
   logic [7:0] ans [8];
   int         idx = 0;
   int         len;

   task automatic send();
      for (int i = 0; i < len; i++) begin
         rx_valid <= 1'b1;
         rx_data  <= ans[i];
         rx_last  <= (i == len - 1);
         @(posedge clock);
      end
      rx_valid <= 1'b0;
      rx_last  <= 1'b0;
      // Released line shows no stale byte
      rx_data  <= ~ans[len-1];
   endtask

   task automatic answer();
      ans[0] = req[0];
      if (mode == 2'h1) begin
         ans[1] = req[1] | EXC_FLAG;
         ans[2] = exc_code;
         len = 3;
      end else begin
         // Coil bits LSB first, spare bits zero
         ans[1:7] = '{req[1], 8'h05, 8'hCD, 8'h6B, 8'hB2, 8'hCE, 8'h1B};
         len = 8;
      end
      // Prompt or slow answer
      repeat ($urandom_range(8, 1)) @(posedge clock);
      send();
   endtask

   initial begin
      tx_ready = 1'b0;
      rx_valid = 1'b0;
      rx_data  = 8'h00;
      rx_last  = 1'b0;
   end

   always @(posedge clock) begin
      if (tx_valid && tx_ready) begin
         req[idx] = tx_data;
         idx = tx_last ? 0 : idx + 1;
         if (tx_last && mode < 2'h2) answer();
      end
      // Mode 3 asks once; exc_code names the station
      if (mode != 2'h3) asked = 1'b0;
      else if (!asked) begin
         asked = 1'b1;
         ans[0:5] = '{exc_code, FC_RD_COILS, 8'h00, 8'h03, 8'h00, 8'h0D};
         len = 6;
         send();
      end
      // Random stalls on the request stream
      tx_ready <= 1'($urandom_range(1, 0));
   end
endmodule

//--- test/tb_top.sv
`define CHK(g, w) begin total_checks++; if ((g) !== (w)) begin n_errors++; \
   $display("ERROR at %0t: got %h want %h", $time, g, w); end end
module tb_top import mre_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TMO = 50;
   logic clock = 0, rst = 1, cfg_master = 1, cfg_ascii_mode = 0;
   logic legacy_instruction = 0, exec_condition = 0, cfg_data_bits8 = 1;
   logic tx_valid, tx_last, tx_ready, rx_valid, rx_last, buf_we;
   logic [1:0] channel_select = 0, active_channel, mode = 2;
   logic [4:0] own_station = 1;
   logic [7:0] req_station = 0, req_function = 0, tgt, exc_code = 0;
   logic [7:0] tx_data, rx_data, buf_addr, sr [5];
   logic [15:0] req_address = 0, req_count = 0, buf_data;
   logic [15:0] transaction_status_word, words [256];
   logic [63:0] slave_bits = 0;
   int n_errors = 0, total_checks = 0;

   always #4 clock = ~clock;
   always @(negedge clock) if (buf_we === 1'b1) words[buf_addr] = buf_data;

   mre_engine #(.TIMEOUT_CYCLES(TMO)) i_dut (.clock, .rst, .cfg_master,
      .cfg_ascii_mode, .cfg_data_bits8, .own_station,
      .legacy_instruction, .channel_select, .exec_condition, .req_station,
      .req_function, .req_address, .req_count, .transaction_status_word,
      .active_channel, .tx_valid, .tx_data, .tx_last, .tx_ready, .rx_valid,
      .rx_data, .rx_last, .buf_we, .buf_addr, .buf_data, .slave_bits);
   mre_remote_station i_remote (.clock, .tx_valid, .tx_data, .tx_last,
      .tx_ready, .rx_valid, .rx_data, .rx_last, .mode, .exc_code);

   task automatic give_verdict();
      $display("TB: checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic run(input logic [7:0] st, fc, input logic [15:0] cn,
                      input logic [1:0] md, input logic [7:0] ex, code,
                      input logic dn);
      logic [7:0] e [6];
      logic [7:0] b [6];
      int k;
      words = '{default: 16'hXXXX};
      req_address = 16'($urandom);
      e = '{st, fc, req_address[15:8], req_address[7:0], cn[15:8], cn[7:0]};
      b = '{8'hCD, 8'h6B, 8'hB2, 8'hCE, 8'h1B, 8'h00};
      {mode, exc_code, req_station, req_function, req_count} = {md, ex, st, fc, cn};
      exec_condition = 1'b1;
      @(negedge clock);
      exec_condition = 1'b0;
      for (k = 0; k < 400 && transaction_status_word[1:0] === 2'b00; k++)
         @(negedge clock);
      if (k == 400) begin
         n_errors++;
         $display("ERROR at %0t: no status", $time);
         give_verdict();
      end
      `CHK(transaction_status_word[1:0], {!dn, dn})
      if (!dn) `CHK(transaction_status_word[15:8], code)
      @(negedge clock);
      `CHK(transaction_status_word[1:0], 2'b00)
      // Covers the code 05 hold as well
      repeat (TMO + 10) @(negedge clock);
      for (k = 0; k < 6 && dn; k++) `CHK(i_remote.req[k], e[k])
      for (k = 0; k < 3 && dn && md == 0; k++) `CHK(words[k], {b[2*k+1], b[2*k]})
      $display("TB: test done station %h function %h", st, fc);
   endtask

   initial begin
      void'($urandom(68726));
      slave_bits = {$urandom, $urandom};
      repeat (5) @(negedge clock);
      rst = 1'b0;
      own_station = 5'($urandom_range(15, 1));
      tgt = 8'(own_station) + 8'h10;
      channel_select = 2'($urandom_range(3, 1));
      repeat (2) @(negedge clock);
      `CHK(active_channel, channel_select)
      legacy_instruction = 1'b1;
      repeat (2) @(negedge clock);
      `CHK(active_channel, LEGACY_CHAN)
      legacy_instruction = 1'b0;
      run(tgt, FC_RD_COILS, 16'h0025, 2'h0, 0, 0, 1'b1);
      run({3'h0, own_station}, FC_RD_COILS, 16'h0001, 2'h2, 0, ERR_STATION, 0);
      run(tgt, 8'h07, 16'h0001, 2'h2, 0, ERR_FUNC, 0);
      run(tgt, FC_RD_COILS, 16'h0000, 2'h2, 0, ERR_COUNT, 0);
      run(tgt, FC_RD_HOLD, 16'h0081, 2'h2, 0, ERR_COUNT, 0);
      for (int c = 2; c < 7; c++) run(tgt, FC_RD_COILS, 16'h0025, 2'h1,
         8'(c), 8'(c), 0);
      run(tgt, FC_RD_COILS, 16'h0025, 2'h0, 0, 0, 1'b1);
      run(tgt, FC_RD_COILS, 16'h0025, 2'h2, 0, ERR_TIMEOUT, 0);
      run(BCAST_STATION, FC_RD_COILS, 16'h0025, 2'h2, 0, 0, 1'b1);
      cfg_ascii_mode = 1'b1;
      run(tgt, FC_RD_COILS, 16'h0025, 2'h2, 0, ERR_PARAM, 0);
      cfg_data_bits8 = 1'b0;
      run(tgt, FC_RD_COILS, 16'h0025, 2'h0, 0, 0, 1'b1);
      cfg_ascii_mode = 1'b0;
      run(tgt, FC_RD_COILS, 16'h0025, 2'h2, 0, ERR_PARAM, 0);
      cfg_data_bits8 = 1'b1;
      cfg_master = 1'b0;
      run(tgt, FC_RD_COILS, 16'h0025, 2'h2, 0, ERR_PARAM, 0);
      // Far side asks for 13 coils from address 3
      {mode, exc_code} = {2'h3, 8'(own_station)};
      repeat (40) @(negedge clock);
      sr = '{8'(own_station), FC_RD_COILS, 8'h02, slave_bits[10:3],
             {3'h0, slave_bits[15:11]}};
      for (int k = 0; k < 5; k++) `CHK(i_remote.req[k], sr[k])
      $display("TB: test done slave answer");
      give_verdict();
   end
endmodule
